/* logic/asc_cfg.svh */
// Purpose: Timing figures and widths for the static memory host controller.
// Assumes: Clock of 50 MHz, so one cycle is 20 ns.
// Notes: Least times round up to whole cycles by ceiling division.
`ifndef ASC_CFG_SVH
`define ASC_CFG_SVH
`define ASC_CLK_PERIOD_NS 20
`define ASC_ADDR_W 20
`define ASC_DATA_W 16
`define ASC_LANE_LO 0
`define ASC_LANE_HI 1
// Slow grade figures in ns; the fast grade is covered by them.
`define ASC_READ_CYCLE_NS 70
`define ASC_SELECT_ACCESS_MAX_NS 70
`define ASC_OUTEN_ACCESS_MAX_NS 35
`define ASC_DESELECT_TO_FLOAT_MAX_NS 30
`define ASC_WRITE_CYCLE_NS 70
`define ASC_ADDR_TO_END_NS 60
`define ASC_WRITE_PULSE_NS 60
`define ASC_DATA_SETUP_NS 30
`define ASC_WRITE_TO_FLOAT_NS 25
`define ASC_CEIL_CYC(ns) (((ns) + `ASC_CLK_PERIOD_NS - 1) / `ASC_CLK_PERIOD_NS)
// Read data is sampled after the select access time has passed.
`define ASC_READ_CYC `ASC_CEIL_CYC(`ASC_SELECT_ACCESS_MAX_NS)
// Cycles that read data spends in the two flip-flop synchroniser.
`define ASC_SYNC_CYC 2
// Strobe width must cover turn-off plus data setup and the write pulse.
`define ASC_WRITE_CYC `ASC_CEIL_CYC(`ASC_WRITE_TO_FLOAT_NS + `ASC_DATA_SETUP_NS + `ASC_WRITE_PULSE_NS)
// Bus turnaround idle after a read, longer than the float time.
`define ASC_TURN_CYC `ASC_CEIL_CYC(`ASC_DESELECT_TO_FLOAT_MAX_NS)
`define ASC_CNT_W 4
`endif

/* logic/asc_pkg.sv */
// Purpose: Types shared by the static memory host controller.
// Assumes: Constants come from asc_cfg.svh.
// Notes: Pin group travels as one packed struct.
`include "asc_cfg.svh"
package asc_pkg;
  typedef struct packed {
    logic [`ASC_ADDR_W-1:0] word_addr;
    logic chip_sel_n;
    logic chip_sel_hi;
    logic out_en_n;
    logic write_en_n;
    logic lower_lane_sel_n;
    logic upper_lane_sel_n;
  } asc_pins_t;
  typedef enum logic [4:0] {
    ASC_IDLE = 5'b0_0001,
    ASC_READ = 5'b0_0010,
    ASC_WRITE = 5'b0_0100,
    ASC_TURN = 5'b0_1000,
    ASC_HOLD = 5'b1_0000
  } asc_state_t;
endpackage

/* logic/asc_sync.sv */
// Purpose: Two flip-flop synchroniser for one input bit.
// Assumes: Input is asynchronous to mclk.
// Notes: The first stage is read only by the second.
`timescale 1ns/10ps
module asc_sync (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic din,
  output logic dout
);
  logic stage1;
  // Plain double register against metastability.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      stage1 <= 1'b0;
      dout <= 1'b0;
    end else begin
      stage1 <= din;
      dout <= stage1;
    end
  end
endmodule // asc_sync

/* logic/asc_timer.sv */
// Purpose: Loadable down counter for phase timing.
// Assumes: Load value is at least one.
// Notes: Done is a level while the count is zero.
`timescale 1ns/10ps
module asc_timer #(
  parameter int W = 4
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic load,
  input wire logic [W-1:0] value,
  output logic done
);
  logic [W-1:0] count;
  // Load wins over counting so a new phase starts cleanly.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      count <= '0;
    end else if (load) begin
      count <= value;
    end else if (count != '0) begin
      count <= count - 1'b1;
    end
  end
  assign done = (count == '0);
endmodule // asc_timer

/* logic/asc_ctrl.sv */
// Purpose: Host controller driving a 1M x 16 asynchronous static memory.
// Assumes: 50 MHz mclk; timings of the slower grade, which also serve the faster one.
// Notes: Data pins are input, output and enable; the bench resolves the wire.
// Contract
// - Write strobe stays high through every read access.
// - Address valid before or with chip and lane selection.
// - Write happens only with both selects, strobe and a lane active.
// - Strobe, select and lanes high while address changes.
// - Address held valid at least sixty ns before write end.
// - Chip selected at least sixty ns before write end.
// - Strobe pulse and lane selects long enough before write end.
// - Write data valid at least thirty ns before write end.
// - Write data may be released right at write end.
// - Strobe pulse exceeds turn-off plus data setup with enable low.
// - Controller never drives data while memory drives it.
// - Chip deselected before supply drop and for a read cycle after.
`timescale 1ns/10ps
module asc_ctrl
  import asc_pkg::*;
#(
  parameter int ADDR_W = `ASC_ADDR_W,
  parameter int DATA_W = `ASC_DATA_W
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [DATA_W-1:0] req_wdata,
  input wire logic [1:0] req_lanes,
  input wire logic retain_req,
  output logic req_ready,
  output logic rsp_valid,
  output logic [DATA_W-1:0] rsp_rdata,
  output logic retain_ack,
  output asc_pins_t pins,
  input wire logic [DATA_W-1:0] data_io_in,
  output logic [DATA_W-1:0] data_io_out,
  output logic data_io_oe
);
  // The read wait covers the access time and the synchroniser, or stale data would be captured.
  localparam logic [`ASC_CNT_W-1:0] READ_CYC = `ASC_CNT_W'(`ASC_READ_CYC + `ASC_SYNC_CYC);
  localparam logic [`ASC_CNT_W-1:0] WRITE_CYC = `ASC_CNT_W'(`ASC_WRITE_CYC);
  localparam logic [`ASC_CNT_W-1:0] TURN_CYC = `ASC_CNT_W'(`ASC_TURN_CYC);
  localparam logic [`ASC_CNT_W-1:0] RECOVER_CYC = `ASC_CNT_W'(`ASC_CEIL_CYC(`ASC_READ_CYCLE_NS));

  asc_state_t state;
  asc_state_t next_state;
  logic timer_load;
  logic [`ASC_CNT_W-1:0] timer_value;
  logic timer_done;
  logic retain_sync;
  logic lanes_any;
  logic [DATA_W-1:0] data_sync;
  logic retain_held;

  // Retention request may come from a supply monitor, so it is synchronised.
  asc_sync u_retain_sync (
    .mclk(mclk),
    .arst_n(arst_n),
    .din(retain_req),
    .dout(retain_sync)
  );

  // Read data is asynchronous to mclk; each bit passes two flip-flops.
  for (genvar i = 0; i < DATA_W; i++) begin : g_dsync
    asc_sync u_dsync (
      .mclk(mclk),
      .arst_n(arst_n),
      .din(data_io_in[i]),
      .dout(data_sync[i])
    );
  end

  asc_timer #(.W(`ASC_CNT_W)) u_timer (
    .mclk(mclk),
    .arst_n(arst_n),
    .load(timer_load),
    .value(timer_value),
    .done(timer_done)
  );

  assign lanes_any = |req_lanes;

  // Phase sequencing; a request without any lane is simply consumed.
  always_comb begin
    next_state = state;
    timer_load = 1'b0;
    timer_value = READ_CYC;
    case (state)
      ASC_IDLE: begin
        if (retain_sync) begin
          next_state = ASC_HOLD;
        end else if (req_valid && req_ready && lanes_any) begin
          timer_load = 1'b1;
          next_state = req_write ? ASC_WRITE : ASC_READ;
          timer_value = req_write ? WRITE_CYC : READ_CYC;
        end
      end
      ASC_READ: begin
        if (timer_done) begin
          // Read data is sampled after sync delay, then the bus turns around.
          timer_load = 1'b1;
          timer_value = TURN_CYC;
          next_state = ASC_TURN;
        end
      end
      ASC_WRITE: begin
        if (timer_done) begin
          timer_load = 1'b1;
          timer_value = TURN_CYC;
          next_state = ASC_TURN;
        end
      end
      ASC_TURN: begin
        if (timer_done) begin
          next_state = ASC_IDLE;
        end
      end
      ASC_HOLD: begin
        if (!retain_sync) begin
          timer_load = 1'b1;
          timer_value = RECOVER_CYC;
          next_state = ASC_TURN;
        end
      end
      default: begin
        next_state = ASC_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state <= ASC_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Ready is a register so the host sees it straight from a flop.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      req_ready <= 1'b0;
    end else begin
      req_ready <= (next_state == ASC_IDLE) && !retain_sync;
    end
  end

  // Address and selects change together on entry, so address is never late.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pins.word_addr <= '0;
      pins.chip_sel_n <= 1'b1;
      pins.chip_sel_hi <= 1'b0;
      pins.out_en_n <= 1'b1;
      pins.lower_lane_sel_n <= 1'b1;
      pins.upper_lane_sel_n <= 1'b1;
    end else if (state == ASC_IDLE && next_state != ASC_IDLE && next_state != ASC_HOLD) begin
      pins.word_addr <= req_addr;
      pins.chip_sel_n <= 1'b0;
      pins.chip_sel_hi <= 1'b1;
      pins.out_en_n <= req_write;
      pins.lower_lane_sel_n <= !req_lanes[`ASC_LANE_LO];
      pins.upper_lane_sel_n <= !req_lanes[`ASC_LANE_HI];
    end else if (next_state != ASC_READ && next_state != ASC_WRITE) begin
      pins.chip_sel_n <= 1'b1;
      pins.chip_sel_hi <= 1'b0;
      pins.out_en_n <= 1'b1;
      pins.lower_lane_sel_n <= 1'b1;
      pins.upper_lane_sel_n <= 1'b1;
    end
  end

  // Strobe falls one cycle after select, so select leads the write.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pins.write_en_n <= 1'b1;
    end else begin
      pins.write_en_n <= !(state == ASC_WRITE && next_state == ASC_WRITE);
    end
  end

  // Drive data only during the write phase; the memory output is off then.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      data_io_out <= '0;
      data_io_oe <= 1'b0;
    end else if (state == ASC_IDLE && next_state == ASC_WRITE) begin
      data_io_out <= req_wdata;
      data_io_oe <= 1'b1;
    end else if (next_state != ASC_WRITE) begin
      data_io_oe <= 1'b0;
    end
  end

  // Capture at end of read; sync adds two cycles past the access time.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rsp_valid <= 1'b0;
      rsp_rdata <= '0;
    end else begin
      rsp_valid <= (state == ASC_READ) && timer_done;
      if ((state == ASC_READ) && timer_done) begin
        rsp_rdata <= data_sync;
      end
    end
  end

  // Acknowledge once the chip is truly deselected for retention.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      retain_held <= 1'b0;
      retain_ack <= 1'b0;
    end else begin
      retain_held <= (state == ASC_HOLD);
      retain_ack <= retain_held && (state == ASC_HOLD);
    end
  end
endmodule // asc_ctrl

/* dv/asc_sram_model.sv */
// Purpose: Behavioural static memory on the far side of the host controller.
// Assumes: Slow grade access time; mclk samples write data and updates the float pattern.
// Notes: Undriven lanes show a pattern that changes every cycle.
`timescale 1ns/10ps
module asc_sram_model
  import asc_pkg::*;
#(
  parameter int ACC_NS = 70,
  parameter int HOLD_NS = 10
) (
  input wire logic mclk,
  input asc_pins_t pins,
  input wire logic [15:0] dq_in,
  output logic [15:0] dq_out
);
  logic [15:0] mem [logic [19:0]];
  logic [15:0] flt = 16'h0000;
  logic [15:0] cap_d;
  logic [15:0] cur;
  logic [15:0] rv;
  logic [19:0] cap_a;
  logic [19:0] addr_late;
  logic [1:0] cap_l;
  logic sel;
  logic rd_ok;
  logic rd_late;
  logic wr;
  assign sel = !pins.chip_sel_n && pins.chip_sel_hi;
  assign rd_ok = sel && !pins.out_en_n && pins.write_en_n;
  assign #(ACC_NS) rd_late = rd_ok;
  // old data held for a while after the address moves.
  assign #(HOLD_NS) addr_late = pins.word_addr;
  assign wr = sel && !pins.write_en_n && !(pins.lower_lane_sel_n && pins.upper_lane_sel_n);
  // blocking capture sees the last edge of the pulse before the pins drop.
  always @(posedge mclk) begin
    if (wr) begin
      cap_a = pins.word_addr;
      cap_l = ~{pins.upper_lane_sel_n, pins.lower_lane_sel_n};
      cap_d = dq_in;
    end
    flt <= ~dq_in;
  end
  always @(negedge wr) begin
    cur = mem.exists(cap_a) ? mem[cap_a] : 16'h0000;
    if (cap_l[0]) cur[7:0] = cap_d[7:0];
    if (cap_l[1]) cur[15:8] = cap_d[15:8];
    mem[cap_a] = cur;
  end
  always @(pins, rd_ok, rd_late, flt, addr_late) begin
    rv = mem.exists(addr_late) ? mem[addr_late] : 16'h0000;
    dq_out = flt;
    if (rd_ok && rd_late && !pins.lower_lane_sel_n) dq_out[7:0] = rv[7:0];
    if (rd_ok && rd_late && !pins.upper_lane_sel_n) dq_out[15:8] = rv[15:8];
  end
endmodule // asc_sram_model

/* dv/asc_ctrl_sva.sv */
// Purpose: Pin timing checks for the memory host controller.
// Assumes: 20 ns mclk, so least times become whole cycles.
// Notes: Bound to asc_ctrl below.
`timescale 1ns/10ps
module asc_ctrl_sva
  import asc_pkg::*;
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic retain_ack,
  input wire logic rsp_valid,
  input asc_pins_t pins,
  input wire logic [15:0] data_io_out,
  input wire logic data_io_oe
);
  logic sel;
  logic lane;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  // Chip and lane activity, used by several checks.
  assign sel = !pins.chip_sel_n && pins.chip_sel_hi;
  assign lane = !(pins.lower_lane_sel_n && pins.upper_lane_sel_n);
  read_no_write_a: assert property (!pins.out_en_n |-> pins.write_en_n)
    else $error("Write strobe low while output enabled");
  no_contend_a: assert property (data_io_oe |-> pins.out_en_n)
    else $error("Data driven while memory outputs enabled");
  write_gate_a: assert property (!pins.write_en_n |-> sel && lane && data_io_oe)
    else $error("Strobe low without full selection");
  addr_steady_a: assert property (sel && $past(sel) |-> $stable(pins.word_addr))
    else $error("Address moved while selected");
  pulse_len_a: assert property ($fell(pins.write_en_n) |-> !pins.write_en_n [*3])
    else $error("Write pulse too short");
  sel_setup_a: assert property ($rose(pins.write_en_n) |->
    $past(sel, 3) && $past(lane, 3) && $past(pins.word_addr, 1) == $past(pins.word_addr, 3))
    else $error("Select or address too late before write end");
  data_setup_a: assert property ($rose(pins.write_en_n) |->
    $past(data_io_oe, 2) && $past(data_io_out, 1) == $past(data_io_out, 2))
    else $error("Write data too late before write end");
  retain_off_a: assert property (retain_ack |-> !sel)
    else $error("Chip selected during retention");
  retain_exit_a: assert property ($fell(retain_ack) |-> !sel [*2])
    else $error("Chip selected too soon after retention");
  cover property (rsp_valid);
  cover property ($rose(pins.write_en_n));
  cover property ($fell(retain_ack));
endmodule // asc_ctrl_sva
bind asc_ctrl asc_ctrl_sva u_asc_ctrl_sva (.mclk(mclk), .arst_n(arst_n), .retain_ack(retain_ack),
  .rsp_valid(rsp_valid), .pins(pins), .data_io_out(data_io_out), .data_io_oe(data_io_oe));

/* dv/tb.sv */
// Purpose: Self-checking bench for the memory host controller.
// Assumes: 50 MHz mclk and a slow grade memory model.
// Notes: Expected words are worked out from the lane masks.
`timescale 1ns/10ps
module tb;
  import asc_pkg::*;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic req_valid = 1'b0;
  logic req_write = 1'b0;
  logic retain_req = 1'b0;
  logic [19:0] req_addr = 20'h0_0000;
  logic [15:0] req_wdata = 16'h0000;
  logic [1:0] req_lanes = 2'h0;
  logic req_ready, rsp_valid, retain_ack, data_io_oe;
  logic [15:0] rsp_rdata, data_io_out, mem_dq;
  wire [15:0] data_io_in;
  asc_pins_t pins;
  int fail_count = 0;
  int num_checks = 0;
  int cyc = 0;
  // Clock of 20 ns.
  always #10 mclk = ~mclk;
  // The controller wins the wire when enabled, else the memory or its float pattern.
  assign data_io_in = data_io_oe ? data_io_out : mem_dq;
  asc_ctrl u_asc_ctrl (.mclk(mclk), .arst_n(arst_n), .req_valid(req_valid), .req_write(req_write),
    .req_addr(req_addr), .req_wdata(req_wdata), .req_lanes(req_lanes), .retain_req(retain_req),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .retain_ack(retain_ack),
    .pins(pins), .data_io_in(data_io_in), .data_io_out(data_io_out), .data_io_oe(data_io_oe));
  asc_sram_model u_asc_sram_model (.mclk(mclk), .pins(pins), .dq_in(data_io_in), .dq_out(mem_dq));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      fail_count++;
    end
  endtask
  task automatic results();
    $display("checks=%0d errors=%0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // One request, launched at the edge where ready is seen and held for one cycle.
  task automatic req(input logic w, input logic [19:0] a, input logic [15:0] d, input logic [1:0] l);
    int n;
    n = 0;
    @(posedge mclk);
    while (req_ready !== 1'b1 && n < 40) begin
      @(posedge mclk);
      n++;
    end
    req_valid <= 1'b1;
    req_write <= w;
    req_addr <= a;
    req_wdata <= d;
    req_lanes <= l;
    @(posedge mclk);
    req_valid <= 1'b0;
  endtask
  task automatic rd(input logic [19:0] a, input logic [15:0] exp);
    int n;
    n = 0;
    req(1'b0, a, 16'h0000, 2'h3);
    while (rsp_valid !== 1'b1 && n < 20) begin
      @(posedge mclk);
      n++;
    end
    chk(rsp_rdata, exp);
  endtask
  task automatic t_reset();
    chk({11'h000, pins.chip_sel_n, pins.chip_sel_hi, pins.write_en_n, pins.out_en_n, req_ready}, 16'h0016);
  endtask
  // Back to back words at both ends of the address range.
  task automatic t_words();
    req(1'b1, 20'h0_0000, 16'h1234, 2'h3);
    req(1'b1, 20'hF_FFFF, 16'hBEEF, 2'h3);
    rd(20'h0_0000, 16'h1234);
    rd(20'hF_FFFF, 16'hBEEF);
  endtask
  // Each lane alone, then a lane-less request that must change nothing.
  task automatic t_lanes();
    req(1'b1, 20'h0_0005, 16'hAAAA, 2'h3);
    req(1'b1, 20'h0_0005, 16'h5566, 2'h1);
    req(1'b1, 20'h0_0005, 16'h77FF, 2'h2);
    req(1'b1, 20'h0_0005, 16'h0000, 2'h0);
    rd(20'h0_0005, 16'h7766);
  endtask
  // Retention entry and exit; contents survive.
  task automatic t_retain();
    int n;
    n = 0;
    retain_req <= 1'b1;
    while (retain_ack !== 1'b1 && n < 10) begin
      @(posedge mclk);
      n++;
    end
    chk({14'h0000, retain_ack, pins.chip_sel_n}, 16'h0003);
    retain_req <= 1'b0;
    rd(20'h0_0005, 16'h7766);
  endtask
  // Cut a hang short.
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      results();
    end
  end
  // Main sequence.
  initial begin
    repeat (20) @(posedge mclk);
    t_reset();
    arst_n <= 1'b1;
    t_words();
    t_lanes();
    t_retain();
    results();
  end
endmodule // tb
